// ==== hw/ssq_pkg.sv ====
package ssq_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned INIT_DELAY_NS = 1_400_000;
  localparam int unsigned INIT_DELAY_CYC = INIT_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_NS = 85_000;
  localparam int unsigned HOLD_CYC = HOLD_NS / CLK_PERIOD_NS;
  localparam int unsigned PG_DELAY_NS = 440_000;
  localparam int unsigned PG_DELAY_CYC = PG_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned VID_SAMPLE_HZ = 3_000_000;
  localparam int unsigned VID_DIV_CYC = CLK_HZ / VID_SAMPLE_HZ;
  localparam int unsigned VID_STABLE_READS = 3;
  localparam int unsigned DEFAULT_STEP_HZ = 330_000;
  localparam int unsigned DEFAULT_STEP_CYC = CLK_HZ / DEFAULT_STEP_HZ;
  localparam int unsigned STEP_DIV = 25;
  localparam int unsigned STEP_CYC_PER_KOHM = (CLK_HZ / 1_000_000) / STEP_DIV;
  localparam int unsigned TIMER_W = 18;

  // ************************************************************
  // Reference levels, in 6.25 mV steps
  // ************************************************************
  localparam int unsigned STEP_UV = 6_250;
  localparam int unsigned BOOT_LEVEL_UV = 1_100_000;
  localparam logic [7:0] BOOT_CODE = 8'(BOOT_LEVEL_UV / STEP_UV);
  localparam logic [4:0] TABLE5_NO_LOAD = 5'h1f;
  localparam logic [7:0] VID_OFF_LO = 8'h00;
  localparam logic [7:0] VID_OFF_HI = 8'hff;

  // ************************************************************
  // Modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_STEP_A = 2'h0,
    MODE_STEP_B = 2'h1,
    MODE_TABLE5 = 2'h2,
    MODE_TABLE6 = 2'h3
  } ssq_mode_e;

  typedef enum logic [6:0] {
    ST_SHUTDOWN = 7'h01,
    ST_INIT_DELAY = 7'h02,
    ST_RAMP1 = 7'h04,
    ST_HOLD = 7'h08,
    ST_RAMP2 = 7'h10,
    ST_PG_DELAY = 7'h20,
    ST_REGULATE = 7'h40
  } ssq_state_e;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_RAMP = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_VID = 12'h00c;
  localparam logic [11:0] REG_IRQ_STAT = 12'h010;
  localparam logic [11:0] REG_IRQ_MASK = 12'h014;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PHASE_LSB = 2;
  localparam int unsigned STATUS_PG_BIT = 8;
  localparam int unsigned STATUS_REF_LSB = 16;
  localparam int unsigned VID_VALID_BIT = 8;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [1:0] CTRL_PHASE_RST = 2'h3;
  localparam logic [9:0] RAMP_RST = 10'h000;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_PG = 0;
  localparam int unsigned IRQ_DROP = 1;
  localparam int unsigned IRQ_VID = 2;

endpackage

// ==== hw/ssq_sequencer.sv ====
module ssq_sequencer #(
  parameter int unsigned INIT_DELAY_CYC = ssq_pkg::INIT_DELAY_CYC,
  parameter int unsigned HOLD_CYC = ssq_pkg::HOLD_CYC,
  parameter int unsigned PG_DELAY_CYC = ssq_pkg::PG_DELAY_CYC
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Comparator and supply-good levels
  input wire logic BIAS_POR_OK_IN,
  input wire logic ENABLE_ABOVE_IN,
  input wire logic FOURTH_PHASE_ENABLE_OK_IN,
  input wire logic FIRST_DRIVER_BIAS_RAIL_OK_IN,
  input wire logic DRIVER_BIAS_RAIL2_OK_IN,
  input wire logic DRIVER_BIAS_RAIL3_OK_IN,
  // Processor identification code
  input wire logic [7:0] VOLTAGE_IDENTIFICATION_IN,
  // Converter side
  output logic [3:0] PHASE_OE_N_OUT,
  output logic [7:0] REF_CODE_OUT,
  output logic POWER_GOOD_OUT,
  output logic IRQ_OUT
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ssq_pkg::ssq_state_e state;
    logic [ssq_pkg::TIMER_W-1:0] timer;
    logic [15:0] step_cnt;
    logic [7:0] ref_code;
    logic [7:0] target;
    logic pg;
    logic [5:0] vid_div;
    logic [7:0] vid_last;
    logic [1:0] vid_reps;
    logic [7:0] vid_code;
    logic vid_seen;
    logic [1:0] mode;
    logic [1:0] phases;
    logic [9:0] ramp_kohm;
    logic [ssq_pkg::IRQ_W-1:0] irq_stat;
    logic [ssq_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] prdata;
  } ssq_regs_s;

  ssq_regs_s s_q;
  ssq_regs_s s_d;
  logic conds_ok;
  logic vid_valid;
  logic no_load;
  logic vid_tick;
  logic step_tick;
  logic [15:0] step_cyc;
  logic addr_hit;
  logic [31:0] rdata;
  logic apb_wr;
  logic [ssq_pkg::IRQ_W-1:0] irq_set;
  logic [ssq_pkg::IRQ_W-1:0] irq_clr;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    s_d = s_q;
    irq_set = '0;
    irq_clr = '0;
    // Every start condition at once; rails 2 and 3 only matter with internal phases
    conds_ok = BIAS_POR_OK_IN
      & ENABLE_ABOVE_IN
      & FOURTH_PHASE_ENABLE_OK_IN
      & FIRST_DRIVER_BIAS_RAIL_OK_IN
      & ((s_q.phases == 2'h0) | (DRIVER_BIAS_RAIL2_OK_IN & DRIVER_BIAS_RAIL3_OK_IN));
    vid_valid = s_q.vid_seen & (s_q.vid_code != ssq_pkg::VID_OFF_LO)
      & (s_q.vid_code != ssq_pkg::VID_OFF_HI);
    // Until a code is accepted the five-bit mode cannot know it is not no-load
    no_load = (s_q.mode == ssq_pkg::MODE_TABLE5)
      & (~s_q.vid_seen | (s_q.vid_code[4:0] == ssq_pkg::TABLE5_NO_LOAD));
    // Grounded ramp pin reads as zero resistance
    step_cyc = (s_q.ramp_kohm == 10'h000) ? 16'(ssq_pkg::DEFAULT_STEP_CYC)
      : 16'(s_q.ramp_kohm * ssq_pkg::STEP_CYC_PER_KOHM);
    step_tick = (s_q.step_cnt >= step_cyc - 16'h0001);

    // Code sampler on the 3 MHz enable; a code needs three equal readings
    vid_tick = (s_q.vid_div == 6'(ssq_pkg::VID_DIV_CYC - 1));
    s_d.vid_div = vid_tick ? 6'h00 : s_q.vid_div + 6'h01;
    if (vid_tick) begin
      if (VOLTAGE_IDENTIFICATION_IN != s_q.vid_last) begin
        s_d.vid_last = VOLTAGE_IDENTIFICATION_IN;
        s_d.vid_reps = 2'h1;
      end else if (s_q.vid_reps != 2'(ssq_pkg::VID_STABLE_READS - 1)) begin
        s_d.vid_reps = s_q.vid_reps + 2'h1;
      end else if (!s_q.vid_seen || (s_q.vid_code != s_q.vid_last)) begin
        s_d.vid_code = s_q.vid_last;
        s_d.vid_seen = 1'b1;
        irq_set[ssq_pkg::IRQ_VID] = 1'b1;
      end
    end

    // Sequencer; loss of any condition wins over every state
    if (!conds_ok && (s_q.state != ssq_pkg::ST_SHUTDOWN)) begin
      s_d.state = ssq_pkg::ST_SHUTDOWN;
      s_d.ref_code = 8'h00;
      s_d.pg = 1'b0;
      irq_set[ssq_pkg::IRQ_DROP] = 1'b1;
    end else begin
      unique case (s_q.state)
        ssq_pkg::ST_SHUTDOWN: begin
          s_d.ref_code = 8'h00;
          s_d.pg = 1'b0;
          // Other modes start with no further qualification
          if (conds_ok && !no_load) begin
            s_d.state = ssq_pkg::ST_INIT_DELAY;
            s_d.timer = '0;
          end
        end
        ssq_pkg::ST_INIT_DELAY: begin
          // Reference is left at zero for the whole delay
          if (s_q.timer == ssq_pkg::TIMER_W'(INIT_DELAY_CYC - 1)) begin
            s_d.state = ssq_pkg::ST_RAMP1;
            s_d.step_cnt = '0;
          end else begin
            s_d.timer = s_q.timer + 1'b1;
          end
        end
        ssq_pkg::ST_RAMP1: begin
          s_d.step_cnt = step_tick ? 16'h0000 : s_q.step_cnt + 16'h0001;
          if (step_tick) begin
            s_d.ref_code = s_q.ref_code + 8'h01;
            if (s_q.ref_code + 8'h01 == ssq_pkg::BOOT_CODE) begin
              s_d.state = ssq_pkg::ST_HOLD;
              s_d.timer = '0;
            end
          end
        end
        ssq_pkg::ST_HOLD: begin
          // Fixed part first, then wait for a validated code
          if (s_q.timer != ssq_pkg::TIMER_W'(HOLD_CYC - 1)) begin
            s_d.timer = s_q.timer + 1'b1;
          end else if (vid_valid) begin
            s_d.state = ssq_pkg::ST_RAMP2;
            s_d.target = s_q.vid_code;
            s_d.step_cnt = '0;
          end
        end
        ssq_pkg::ST_RAMP2: begin
          // Target is frozen at hold exit; later code changes are not followed
          if (s_q.ref_code == s_q.target) begin
            s_d.state = ssq_pkg::ST_PG_DELAY;
            s_d.timer = '0;
          end else begin
            s_d.step_cnt = step_tick ? 16'h0000 : s_q.step_cnt + 16'h0001;
            if (step_tick) begin
              // Either direction, the boot level may lie above the target
              s_d.ref_code = (s_q.target > s_q.ref_code) ? s_q.ref_code + 8'h01
                : s_q.ref_code - 8'h01;
            end
          end
        end
        ssq_pkg::ST_PG_DELAY: begin
          if (s_q.timer == ssq_pkg::TIMER_W'(PG_DELAY_CYC - 1)) begin
            s_d.state = ssq_pkg::ST_REGULATE;
            s_d.pg = 1'b1;
            irq_set[ssq_pkg::IRQ_PG] = 1'b1;
          end else begin
            s_d.timer = s_q.timer + 1'b1;
          end
        end
        ssq_pkg::ST_REGULATE: begin
          s_d.pg = 1'b1;
        end
        default: begin
          s_d.state = ssq_pkg::ST_SHUTDOWN;
        end
      endcase
    end

    // APB decode; reads are latched in the setup cycle so data come from flops
    addr_hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (PADDR_IN)
      ssq_pkg::REG_CTRL: begin
        rdata[ssq_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
        rdata[ssq_pkg::CTRL_PHASE_LSB +: 2] = s_q.phases;
      end
      ssq_pkg::REG_RAMP: rdata[9:0] = s_q.ramp_kohm;
      ssq_pkg::REG_STATUS: begin
        rdata[6:0] = s_q.state;
        rdata[ssq_pkg::STATUS_PG_BIT] = s_q.pg;
        rdata[ssq_pkg::STATUS_REF_LSB +: 8] = s_q.ref_code;
      end
      ssq_pkg::REG_VID: begin
        rdata[7:0] = s_q.vid_code;
        rdata[ssq_pkg::VID_VALID_BIT] = vid_valid;
      end
      ssq_pkg::REG_IRQ_STAT: rdata[ssq_pkg::IRQ_W-1:0] = s_q.irq_stat;
      ssq_pkg::REG_IRQ_MASK: rdata[ssq_pkg::IRQ_W-1:0] = s_q.irq_mask;
      default: addr_hit = 1'b0;
    endcase
    if (PSEL_IN && !PENABLE_IN) begin
      s_d.prdata = rdata;
    end
    apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & addr_hit;
    if (apb_wr) begin
      unique case (PADDR_IN)
        ssq_pkg::REG_CTRL: begin
          s_d.mode = PWDATA_IN[ssq_pkg::CTRL_MODE_LSB +: 2];
          s_d.phases = PWDATA_IN[ssq_pkg::CTRL_PHASE_LSB +: 2];
        end
        ssq_pkg::REG_RAMP: s_d.ramp_kohm = PWDATA_IN[9:0];
        ssq_pkg::REG_IRQ_STAT: irq_clr = PWDATA_IN[ssq_pkg::IRQ_W-1:0];
        ssq_pkg::REG_IRQ_MASK: s_d.irq_mask = PWDATA_IN[ssq_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s_q <= '0;
      s_q.state <= ssq_pkg::ST_SHUTDOWN;
      s_q.mode <= ssq_pkg::CTRL_MODE_RST;
      s_q.phases <= ssq_pkg::CTRL_PHASE_RST;
      s_q.ramp_kohm <= ssq_pkg::RAMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Drivers stay off while in shutdown
  assign PHASE_OE_N_OUT = {4{s_q.state == ssq_pkg::ST_SHUTDOWN}};
  assign REF_CODE_OUT = s_q.ref_code;
  assign POWER_GOOD_OUT = s_q.pg;
  assign IRQ_OUT = |(s_q.irq_stat & s_q.irq_mask);
  assign PRDATA_OUT = s_q.prdata;
  assign PREADY_OUT = PSEL_IN & PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_hit;

  // ************************************************************
  // Assertions
  // ************************************************************
  phase_hiz_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN) |-> (PHASE_OE_N_OUT == 4'hf))
    else $error("phase outputs driven in shutdown");

  bias_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && !BIAS_POR_OK_IN)
    |=> (s_q.state == ssq_pkg::ST_SHUTDOWN))
    else $error("left shutdown without bias supply good");

  enable_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && !ENABLE_ABOVE_IN)
    |=> (s_q.state == ssq_pkg::ST_SHUTDOWN))
    else $error("left shutdown without enable");

  ph4_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && !FOURTH_PHASE_ENABLE_OK_IN)
    |=> (s_q.state == ssq_pkg::ST_SHUTDOWN))
    else $error("left shutdown without fourth phase enable");

  rail_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && (!FIRST_DRIVER_BIAS_RAIL_OK_IN
      || (s_q.phases != 2'h0 && !(DRIVER_BIAS_RAIL2_OK_IN && DRIVER_BIAS_RAIL3_OK_IN))))
    |=> (s_q.state == ssq_pkg::ST_SHUTDOWN))
    else $error("left shutdown without driver rails");

  start_now_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && conds_ok && s_q.mode != ssq_pkg::MODE_TABLE5)
    |=> (s_q.state == ssq_pkg::ST_INIT_DELAY))
    else $error("start delayed in unqualified mode");

  no_load_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_SHUTDOWN && s_q.mode == ssq_pkg::MODE_TABLE5
      && s_q.vid_code[4:0] == ssq_pkg::TABLE5_NO_LOAD)
    |=> (s_q.state == ssq_pkg::ST_SHUTDOWN))
    else $error("started on no-load code");

  init_len_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_RAMP1 && $past(s_q.state) == ssq_pkg::ST_INIT_DELAY)
    |-> ($past(s_q.timer) == ssq_pkg::TIMER_W'(INIT_DELAY_CYC - 1) && s_q.ref_code == 8'h00))
    else $error("initial delay length wrong");

  boot_stop_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_HOLD) |-> (s_q.ref_code == ssq_pkg::BOOT_CODE))
    else $error("hold not at boot level");

  hold_exit_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_RAMP2 && $past(s_q.state) == ssq_pkg::ST_HOLD)
    |-> ($past(s_q.timer) == ssq_pkg::TIMER_W'(HOLD_CYC - 1)))
    else $error("hold left before fixed time");

  valid_code_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_HOLD && !vid_valid)
    |=> (s_q.state != ssq_pkg::ST_RAMP2))
    else $error("second ramp on invalid code");

  step_size_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ($past(s_q.state) != ssq_pkg::ST_SHUTDOWN && s_q.state != ssq_pkg::ST_SHUTDOWN
      && $changed(s_q.ref_code))
    |-> (s_q.ref_code - $past(s_q.ref_code) == 8'h01
      || $past(s_q.ref_code) - s_q.ref_code == 8'h01))
    else $error("reference moved more than one step");

  step_time_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ($past(s_q.state) != ssq_pkg::ST_SHUTDOWN && s_q.state != ssq_pkg::ST_SHUTDOWN
      && $changed(s_q.ref_code))
    |-> ($past(s_q.step_cnt) >= $past(step_cyc) - 16'h0001))
    else $error("reference stepped before period end");

  pg_delay_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(s_q.pg) |-> ($past(s_q.state) == ssq_pkg::ST_PG_DELAY
      && $past(s_q.timer) == ssq_pkg::TIMER_W'(PG_DELAY_CYC - 1)))
    else $error("power good raised without full delay");

  pg_low_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state != ssq_pkg::ST_REGULATE) |-> !POWER_GOOD_OUT)
    else $error("power good high before regulation");

  vid_accept_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $changed(s_q.vid_code) |-> ($past(s_q.vid_reps) == 2'h2 && $past(vid_tick)
      && $past(VOLTAGE_IDENTIFICATION_IN) == s_q.vid_code))
    else $error("code accepted without three equal samples");

  drop_out_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !conds_ok |=> (s_q.state == ssq_pkg::ST_SHUTDOWN && !POWER_GOOD_OUT))
    else $error("condition lost without shutdown");

  init_ref_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_INIT_DELAY) |-> (s_q.ref_code == 8'h00))
    else $error("reference moved during initial delay");

  target_ok_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_RAMP2)
    |-> (s_q.target != ssq_pkg::VID_OFF_LO && s_q.target != ssq_pkg::VID_OFF_HI))
    else $error("second ramp toward an invalid code");

  ramp_end_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (s_q.state == ssq_pkg::ST_PG_DELAY) |-> (s_q.ref_code == s_q.target))
    else $error("power good delay before reaching target");

endmodule

// ==== dv/ssq_cpu_model.sv ====
// ************************************************************
// Processor model driving the identification code lines
// ************************************************************
module ssq_cpu_model (
  // Clock
  input wire logic clk_in,
  // Requested code and how long the lines take to settle on it
  input wire logic [7:0] code_in,
  input wire logic [3:0] lag_in,
  // Code lines towards the sequencer
  output logic [7:0] vid_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] out_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;

  // Lines toggle every cycle while settling, so no half-changed code looks stable
  always_ff @(posedge clk_in) begin
    if (out_q !== code_in && cnt_q < lag_in) begin
      cnt_q <= cnt_q + 4'h1;
      out_q <= ~out_q;
    end else begin
      cnt_q <= 4'h0;
      out_q <= code_in;
    end
  end

  assign vid_out = out_q;
endmodule

// ==== dv/startup_soft_start_sequencer_tb.sv ====
module startup_soft_start_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Short counts keep the run brief; expectations derive from these
  localparam int INIT_C = 20;
  localparam int HOLD_C = 10;
  localparam int PG_C = 15;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] cond = 6'h00;
  logic [7:0] req = 8'h00;
  logic [7:0] voltage_identification;
  logic [3:0] oe_n;
  logic [7:0] ref_c;
  logic pg;
  logic irq;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int dt;

  // Condition bits: bias, enable, fourth phase, rail 1, rail 2, rail 3
  ssq_sequencer #(.INIT_DELAY_CYC(INIT_C), .HOLD_CYC(HOLD_C), .PG_DELAY_CYC(PG_C))
  u_ssq_sequencer (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .BIAS_POR_OK_IN(cond[0]), .ENABLE_ABOVE_IN(cond[1]),
    .FOURTH_PHASE_ENABLE_OK_IN(cond[2]), .FIRST_DRIVER_BIAS_RAIL_OK_IN(cond[3]),
    .DRIVER_BIAS_RAIL2_OK_IN(cond[4]), .DRIVER_BIAS_RAIL3_OK_IN(cond[5]),
    .VOLTAGE_IDENTIFICATION_IN(voltage_identification), .PHASE_OE_N_OUT(oe_n), .REF_CODE_OUT(ref_c),
    .POWER_GOOD_OUT(pg), .IRQ_OUT(irq));

  ssq_cpu_model u_ssq_cpu_model (.clk_in(clk), .code_in(req), .lag_in(4'h9), .vid_out(voltage_identification));

  // ************************************************************
  // Clock, timeout and shared tasks
  // ************************************************************
  always #5 clk = ~clk;

  // A hang counts as a failure and still reaches the report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("apb_wait", 1, n);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  // Cycles until the reference moves, left in dt
  task automatic wref(input int lim);
    logic [7:0] p;
    p = ref_c;
    dt = 0;
    do begin
      @(posedge clk);
      dt++;
    end while (ref_c === p && dt < lim);
  endtask

  task automatic ramp1(input logic [5:0] c);
    cond <= c;
    wref(INIT_C + 40);
    chk("init_delay", 1, dt >= INIT_C + 4 && dt <= INIT_C + 7);
    chk("oe_run", 0, oe_n);
    for (int i = 2; i <= 176; i++) begin
      wref(20);
      chk("ref_up", i, ref_c);
      chk("step_dt", 4, dt);
    end
    chk("pg_ramp", 0, pg);
  endtask

  task automatic ramp2(input logic [7:0] tgt);
    logic [7:0] e;
    for (int k = 0; k < 256 && ref_c !== tgt; k++) begin
      e = (tgt > ref_c) ? ref_c + 8'h01 : ref_c - 8'h01;
      wref(20);
      chk("ref_two", e, ref_c);
      chk("step_two", 4, dt);
    end
    dt = 0;
    while (pg !== 1'b1 && dt < PG_C + 20) begin
      @(posedge clk);
      dt++;
    end
    chk("pg_delay", 1, dt >= PG_C && dt <= PG_C + 3);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("oe_reset", 32'hf, oe_n);
    rdchk("ctrl", ssq_pkg::REG_CTRL, 32'h0000_000c);
    rdchk("ramp", ssq_pkg::REG_RAMP, 32'h0000_0000);
    rdchk("status", ssq_pkg::REG_STATUS, 32'h0000_0001);
    rdchk("mask", ssq_pkg::REG_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("slverr", 1, err);
    rdchk("unmapped", 12'h020, 32'h0000_0000);
    apb(1'b1, ssq_pkg::REG_RAMP, 32'h0000_0001);
    req <= 8'h50;
    // Each single missing condition keeps the converter off
    for (int i = 0; i < 6; i++) begin
      cond <= ~(6'h01 << i);
      repeat (40) @(posedge clk);
      chk("blocked", 32'hf, oe_n);
    end
    // Single-phase set-up ignores rails 2 and 3; downward second ramp
    cond <= 6'h0e;
    apb(1'b1, ssq_pkg::REG_CTRL, 32'h0000_0000);
    ramp1(6'h0f);
    wref(HOLD_C + 40);
    chk("hold", 1, dt >= HOLD_C + 3 && dt <= HOLD_C + 8);
    chk("ref_hold_exit", 175, ref_c);
    ramp2(8'h50);
    chk("irq_masked", 0, irq);
    apb(1'b0, ssq_pkg::REG_IRQ_STAT, 32'h0000_0000);
    chk("stat_pg", 1, rd[ssq_pkg::IRQ_PG]);
    chk("stat_vid", 1, rd[ssq_pkg::IRQ_VID]);
    apb(1'b1, ssq_pkg::REG_IRQ_MASK, 32'h0000_0003);
    @(posedge clk);
    chk("irq_on", 1, irq);
    apb(1'b1, ssq_pkg::REG_IRQ_STAT, 32'h0000_0007);
    @(posedge clk);
    chk("irq_clr", 0, irq);
    // Losing enable drops straight back to the off state
    cond <= 6'h0d;
    repeat (2) @(posedge clk);
    chk("drop_oe", 32'hf, oe_n);
    chk("drop_pg", 0, pg);
    chk("drop_ref", 0, ref_c);
    chk("irq_drop", 1, irq);
    // Invalid code stretches the hold until a valid one arrives
    apb(1'b1, ssq_pkg::REG_CTRL, 32'h0000_000d);
    req <= 8'hff;
    ramp1(6'h3f);
    wref(300);
    chk("hold_invalid", 300, dt);
    req <= 8'hb4;
    wref(400);
    chk("ref_up_two", 177, ref_c);
    ramp2(8'hb4);
    rdchk("vid", ssq_pkg::REG_VID, 32'h0000_01b4);
    // Five-bit table refuses the no-load code
    cond <= 6'h00;
    apb(1'b1, ssq_pkg::REG_CTRL, 32'h0000_0002);
    req <= 8'h1f;
    repeat (150) @(posedge clk);
    cond <= 6'h3f;
    repeat (150) @(posedge clk);
    chk("no_load", 32'hf, oe_n);
    req <= 8'h14;
    repeat (150) @(posedge clk);
    chk("load_seen", 0, oe_n);
    // Six-bit table starts at once; grounded resistor uses the default rate
    cond <= 6'h00;
    apb(1'b1, ssq_pkg::REG_CTRL, 32'h0000_000f);
    apb(1'b1, ssq_pkg::REG_RAMP, 32'h0000_0000);
    cond <= 6'h3f;
    repeat (2) @(posedge clk);
    chk("six_bit", 0, oe_n);
    wref(INIT_C + 400);
    wref(400);
    chk("default_step", 303, dt);
    tally_and_finish();
  end
endmodule
